// *** verilog/lpm_ctrl_pkg.sv ***
// Package for the operating-mode controller: modes, masks, sizes.
// Assumes a single 100 MHz core clock and an active-low async reset.
package lpm_ctrl_pkg;

  typedef enum logic [2:0] {
    full_run_state,
    processor_off_state,
    standby_state,
    off_state,
    rtc_only_state,
    shutdown_state
  } mode_type;

  localparam int unsigned MODE_W = 3;
  localparam int unsigned BACKUP_BYTES = 32;
  localparam int unsigned BACKUP_AW = 5;
  localparam int unsigned BYTE_W = 8;
  localparam logic [BYTE_W-1:0] BACKUP_RESET = 8'h00;

  // Wake mask bit positions, bit 0 any maskable source, bit 1 I/O, bit 2 RTC
  localparam int unsigned WAKE_ANY = 0;
  localparam int unsigned WAKE_IO = 1;
  localparam int unsigned WAKE_RTC = 2;

endpackage

// *** verilog/low_power_mode_control.sv ***
// Operating-mode controller: clock, oscillator, supply and pin-hold gating.
// Assumes software requests on a one-cycle strobe and the core signals
// interrupt entry and return as one-cycle pulses, all on core_clk_i.

// Behaviour
// R1 - One run state, software picks reduced state
// R2 - Enabled interrupt wakes from three low states
// R3 - Interrupt return restores prior reduced state
// R4 - Rtc-only and shutdown cut core supply
// R5 - Off state keeps low clocks when requested
// R6 - Off-state gating touches internal clocks only
// R7 - 32-byte backup area survives except shutdown
// R8 - Per-state clock options and pin hold
module low_power_mode_control (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic mode_req_i,
  input wire logic [2:0] mode_sel_i,
  input wire logic irq_any_i,
  input wire logic irq_io_i,
  input wire logic irq_rtc_i,
  input wire logic irq_return_i,
  input wire logic sub_main_clock_en_i,
  input wire logic fll_en_i,
  input wire logic dco_en_i,
  input wire logic module_oscillator_clock_en_i,
  input wire logic internal_reference_osc_en_i,
  input wire logic lf_periph_req_i,
  input wire logic ext_clk_sel_i,
  input wire logic bk_we_i,
  input wire logic [4:0] bk_addr_i,
  input wire logic [7:0] bk_wdata_i,
  output logic [2:0] mode_o,
  output logic wake_o,
  output logic main_clk_en_o,
  output logic sub_main_clk_en_o,
  output logic fll_en_o,
  output logic dco_en_o,
  output logic module_oscillator_clock_en_o,
  output logic internal_reference_osc_en_o,
  output logic lf_clk_en_o,
  output logic core_supply_en_o,
  output logic gpio_hold_o,
  output logic [7:0] bk_rdata_o
);

  lpm_ctrl_pkg::mode_type mode;
  lpm_ctrl_pkg::mode_type saved_mode;
  logic in_isr;
  logic [lpm_ctrl_pkg::BYTE_W-1:0] backup_mem [lpm_ctrl_pkg::BACKUP_BYTES];

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // ---------------------------------------------------------------
  // Wake decoding
  // ---------------------------------------------------------------
  function automatic logic wake_ok(lpm_ctrl_pkg::mode_type m, logic a, logic io, logic rtc);
    case (m)
      lpm_ctrl_pkg::processor_off_state: wake_ok = a | io | rtc;
      lpm_ctrl_pkg::standby_state: wake_ok = a | io | rtc;
      lpm_ctrl_pkg::off_state: wake_ok = io;
      default: wake_ok = 1'b0;
    endcase
  endfunction

  // Wake is blocked during service so a nested event cannot overwrite the saved mode
  logic wake_ev;
  assign wake_ev = !in_isr && wake_ok(mode, irq_any_i, irq_io_i, irq_rtc_i); // [R2]

  function automatic lpm_ctrl_pkg::mode_type decode_sel(logic [2:0] s);
    case (s)
      lpm_ctrl_pkg::processor_off_state: decode_sel = lpm_ctrl_pkg::processor_off_state;
      lpm_ctrl_pkg::standby_state: decode_sel = lpm_ctrl_pkg::standby_state;
      lpm_ctrl_pkg::off_state: decode_sel = lpm_ctrl_pkg::off_state;
      lpm_ctrl_pkg::rtc_only_state: decode_sel = lpm_ctrl_pkg::rtc_only_state;
      lpm_ctrl_pkg::shutdown_state: decode_sel = lpm_ctrl_pkg::shutdown_state;
      default: decode_sel = lpm_ctrl_pkg::full_run_state;
    endcase
  endfunction

  // ---------------------------------------------------------------
  // Mode state
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode <= lpm_ctrl_pkg::full_run_state;
      saved_mode <= lpm_ctrl_pkg::full_run_state;
      in_isr <= 1'b0;
    end
    else if (wake_ev)
    begin
      saved_mode <= mode; // [R3]
      mode <= lpm_ctrl_pkg::full_run_state; // [R2]
      in_isr <= 1'b1;
    end
    else if (in_isr && irq_return_i)
    begin
      mode <= saved_mode; // [R3]
      in_isr <= 1'b0;
    end
    else if (mode_req_i && mode == lpm_ctrl_pkg::full_run_state && !in_isr)
    begin
      mode <= decode_sel(mode_sel_i); // [R1]
    end
  end

  mode_select_a: assert property (mode_req_i && mode == lpm_ctrl_pkg::full_run_state && !in_isr // [R1]
    && mode_sel_i == lpm_ctrl_pkg::standby_state |=> mode == lpm_ctrl_pkg::standby_state)
    else $error("mode select");
  mode_refuse_a: assert property (mode_req_i && mode != lpm_ctrl_pkg::full_run_state && !wake_ev // [R1]
    |=> $stable(mode))
    else $error("request taken outside run");
  wake_run_a: assert property (wake_ev |=> (mode == lpm_ctrl_pkg::full_run_state && wake_o) ##1 !wake_o) // [R2]
    else $error("wake failed");
  off_io_a: assert property (mode == lpm_ctrl_pkg::off_state && !in_isr && irq_io_i |=> in_isr) // [R2]
    else $error("off io wake");
  mode_restore_a: assert property (wake_ev ##1 (!wake_ev && irq_return_i) |=> mode == $past(mode, 2)) // [R3]
    else $error("restore wrong");
  // Rtc-only has no powered core, so only a reset leaves it
  rtc_stay_a: assert property (mode == lpm_ctrl_pkg::rtc_only_state // [R4]
    |=> mode == lpm_ctrl_pkg::rtc_only_state) else $error("rtc-only left without reset");

  // ---------------------------------------------------------------
  // Gating outputs, registered from the current mode register, one cycle behind it
  // ---------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mode_o <= lpm_ctrl_pkg::full_run_state;
      wake_o <= 1'b0;
      main_clk_en_o <= 1'b1;
      sub_main_clk_en_o <= 1'b0;
      fll_en_o <= 1'b0;
      dco_en_o <= 1'b0;
      module_oscillator_clock_en_o <= 1'b0;
      internal_reference_osc_en_o <= 1'b0;
      lf_clk_en_o <= 1'b0;
      core_supply_en_o <= 1'b1;
      gpio_hold_o <= 1'b0;
    end
    else
    begin
      mode_o <= mode;
      wake_o <= wake_ev;
      main_clk_en_o <= (mode == lpm_ctrl_pkg::full_run_state); // [R8]
      sub_main_clk_en_o <= (mode <= lpm_ctrl_pkg::processor_off_state) && sub_main_clock_en_i; // [R8]
      fll_en_o <= (mode <= lpm_ctrl_pkg::processor_off_state) && fll_en_i; // [R8]
      dco_en_o <= (mode <= lpm_ctrl_pkg::processor_off_state) && dco_en_i; // [R8]
      module_oscillator_clock_en_o <= (mode <= lpm_ctrl_pkg::processor_off_state) && module_oscillator_clock_en_i; // [R8]
      internal_reference_osc_en_o <= (mode <= lpm_ctrl_pkg::standby_state) && internal_reference_osc_en_i; // [R8]
      // External source is never gated; internal low clocks follow requests except in shutdown
      case (mode)
        lpm_ctrl_pkg::off_state: lf_clk_en_o <= lf_periph_req_i || ext_clk_sel_i; // [R5] [R6]
        lpm_ctrl_pkg::shutdown_state: lf_clk_en_o <= ext_clk_sel_i; // [R6]
        default: lf_clk_en_o <= lf_periph_req_i || ext_clk_sel_i;
      endcase
      core_supply_en_o <= !(mode == lpm_ctrl_pkg::rtc_only_state
                            || mode == lpm_ctrl_pkg::shutdown_state); // [R4]
      gpio_hold_o <= (mode >= lpm_ctrl_pkg::standby_state); // [R8]
    end
  end

  supply_off_a: assert property ((mode == lpm_ctrl_pkg::rtc_only_state // [R4]
    || mode == lpm_ctrl_pkg::shutdown_state) |=> !core_supply_en_o)
    else $error("supply on");
  lf_keep_a: assert property (mode == lpm_ctrl_pkg::off_state && lf_periph_req_i |=> lf_clk_en_o) // [R5]
    else $error("lf clock off");
  ext_clk_a: assert property (ext_clk_sel_i |=> lf_clk_en_o) else $error("ext gated"); // [R6]
  main_clk_a: assert property (mode != lpm_ctrl_pkg::full_run_state |=> !main_clk_en_o) // [R8]
    else $error("main clk on");
  fast_clk_off_a: assert property (mode >= lpm_ctrl_pkg::standby_state // [R8]
    |=> !sub_main_clk_en_o && !fll_en_o && !dco_en_o && !module_oscillator_clock_en_o)
    else $error("fast clock on in standby or deeper");
  pin_hold_a: assert property (mode == lpm_ctrl_pkg::standby_state |=> gpio_hold_o) // [R8]
    else $error("no hold");

  // ---------------------------------------------------------------
  // Backup area, cleared by reset and in every cycle spent in shutdown
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < lpm_ctrl_pkg::BACKUP_BYTES; gi++)
    begin : g_bk
      always_ff @(posedge core_clk_i or negedge rst_n_i)
      begin
        if (!rst_n_i)
          backup_mem[gi] <= lpm_ctrl_pkg::BACKUP_RESET;
        else if (mode == lpm_ctrl_pkg::shutdown_state)
          backup_mem[gi] <= lpm_ctrl_pkg::BACKUP_RESET; // [R7]
        else if (bk_we_i && int'(bk_addr_i) == gi)
          backup_mem[gi] <= bk_wdata_i; // [R7]
      end
    end
  endgenerate

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      bk_rdata_o <= lpm_ctrl_pkg::BACKUP_RESET;
    else
      bk_rdata_o <= backup_mem[bk_addr_i];
  end

  backup_keep_a: assert property (bk_we_i && mode == lpm_ctrl_pkg::full_run_state // [R7]
    ##1 (!bk_we_i && mode != lpm_ctrl_pkg::shutdown_state)
    |=> backup_mem[$past(bk_addr_i, 2)] == $past(bk_wdata_i, 2)) else $error("backup lost");
  backup_clear_a: assert property (mode == lpm_ctrl_pkg::shutdown_state // [R7]
    ##1 mode == lpm_ctrl_pkg::shutdown_state |=> bk_rdata_o == lpm_ctrl_pkg::BACKUP_RESET)
    else $error("backup kept in shutdown");

  // ---------------------------------------------------------------
  // Coverage
  // ---------------------------------------------------------------
  cov_wake: cover property (mode == lpm_ctrl_pkg::standby_state ##1 wake_o);
  cov_off_io: cover property (mode == lpm_ctrl_pkg::off_state ##1 wake_o);
  cov_restore: cover property (in_isr && irq_return_i);
  cov_refused: cover property (mode_req_i && mode != lpm_ctrl_pkg::full_run_state);
  cov_shutdown: cover property (mode == lpm_ctrl_pkg::shutdown_state);

endmodule

// *** testbench/low_power_mode_control_tb.sv ***
// Self-checking bench for the operating-mode controller.
// Assumes the design's own assertions watch cycle timing; inputs change on falling edges.
module low_power_mode_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_i, rst_n_i, mode_req_i, irq_any_i, irq_io_i, irq_rtc_i, irq_return_i, bk_we_i;
  logic sub_main_clock_en_i, fll_en_i, dco_en_i, module_oscillator_clock_en_i, internal_reference_osc_en_i, lf_periph_req_i, ext_clk_sel_i;
  logic [2:0] mode_sel_i, mode_o;
  logic [4:0] bk_addr_i;
  logic [7:0] bk_wdata_i, bk_rdata_o;
  logic wake_o, main_clk_en_o, sub_main_clk_en_o, fll_en_o, dco_en_o, module_oscillator_clock_en_o, internal_reference_osc_en_o, lf_clk_en_o;
  logic core_supply_en_o, gpio_hold_o;
  int errors = 0;
  int checks = 0;

  low_power_mode_control DUT (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .mode_req_i(mode_req_i),
    .mode_sel_i(mode_sel_i), .irq_any_i(irq_any_i), .irq_io_i(irq_io_i), .irq_rtc_i(irq_rtc_i),
    .irq_return_i(irq_return_i), .sub_main_clock_en_i(sub_main_clock_en_i), .fll_en_i(fll_en_i), .dco_en_i(dco_en_i),
    .module_oscillator_clock_en_i(module_oscillator_clock_en_i), .internal_reference_osc_en_i(internal_reference_osc_en_i), .lf_periph_req_i(lf_periph_req_i),
    .ext_clk_sel_i(ext_clk_sel_i), .bk_we_i(bk_we_i), .bk_addr_i(bk_addr_i), .bk_wdata_i(bk_wdata_i),
    .mode_o(mode_o), .wake_o(wake_o), .main_clk_en_o(main_clk_en_o), .sub_main_clk_en_o(sub_main_clk_en_o),
    .fll_en_o(fll_en_o), .dco_en_o(dco_en_o), .module_oscillator_clock_en_o(module_oscillator_clock_en_o), .internal_reference_osc_en_o(internal_reference_osc_en_o),
    .lf_clk_en_o(lf_clk_en_o), .core_supply_en_o(core_supply_en_o), .gpio_hold_o(gpio_hold_o),
    .bk_rdata_o(bk_rdata_o));

  initial
  begin
    core_clk_i = 1'b0;
    forever #5 core_clk_i = ~core_clk_i;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic report_and_stop();
    $display("errors %0d checks %0d", errors, checks);
    if (errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  task automatic do_reset();
    rst_n_i = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
  endtask

  task automatic pulse(ref logic s);
    s = 1'b1;
    tick(1);
    s = 1'b0;
  endtask

  // Bounded wait on a mode or on the wake pulse; running out ends the run
  task automatic wait_for(input logic [2:0] m, input logic on_wake);
    int n;
    n = 0;
    while ((on_wake ? wake_o !== 1'b1 : mode_o !== m) && n < 10)
    begin
      tick(1);
      n++;
    end
    chk(8'(n < 10), 8'h01);
    if (n == 10)
      report_and_stop();
  endtask

  task automatic enter(input logic [2:0] m);
    mode_sel_i = m;
    pulse(mode_req_i);
    wait_for(m, 1'b0);
  endtask

  task automatic bk_write(input logic [4:0] a, input logic [7:0] d);
    bk_addr_i = a;
    bk_wdata_i = d;
    pulse(bk_we_i);
  endtask

  task automatic bk_read(input logic [4:0] a, input logic [7:0] d);
    bk_addr_i = a;
    tick(2);
    chk(bk_rdata_o, d);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_standby();
    chk({3'h0, mode_o, main_clk_en_o, core_supply_en_o}, 8'h03);
    enter(lpm_ctrl_pkg::standby_state);
    chk(8'({main_clk_en_o, sub_main_clk_en_o, fll_en_o, dco_en_o, module_oscillator_clock_en_o, internal_reference_osc_en_o, gpio_hold_o}), 8'h03);
    mode_sel_i = 3'h0;
    pulse(mode_req_i);
    tick(3);
    chk(8'(mode_o), 8'h02);
    irq_any_i = 1'b1;
    wait_for(3'h0, 1'b1);
    irq_any_i = 1'b0;
    pulse(irq_return_i);
    chk(8'({mode_o, main_clk_en_o}), 8'h01);
    wait_for(lpm_ctrl_pkg::standby_state, 1'b0);
  endtask

  task automatic t_off();
    do_reset();
    enter(lpm_ctrl_pkg::processor_off_state);
    chk(8'({main_clk_en_o, sub_main_clk_en_o, fll_en_o, dco_en_o, module_oscillator_clock_en_o, internal_reference_osc_en_o}), 8'h1F);
    irq_rtc_i = 1'b1;
    wait_for(3'h0, 1'b1);
    irq_rtc_i = 1'b0;
    pulse(irq_return_i);
    wait_for(lpm_ctrl_pkg::processor_off_state, 1'b0);
    do_reset();
    lf_periph_req_i = 1'b1;
    enter(lpm_ctrl_pkg::off_state);
    chk(8'({lf_clk_en_o, internal_reference_osc_en_o, core_supply_en_o, gpio_hold_o}), 8'h0B);
    lf_periph_req_i = 1'b0;
    tick(2);
    chk(8'(lf_clk_en_o), 8'h00);
    ext_clk_sel_i = 1'b1;
    tick(2);
    chk(8'(lf_clk_en_o), 8'h01);
    ext_clk_sel_i = 1'b0;
    irq_any_i = 1'b1;
    tick(3);
    chk(8'(mode_o), 8'h03);
    irq_any_i = 1'b0;
    irq_io_i = 1'b1;
    wait_for(3'h0, 1'b1);
    irq_io_i = 1'b0;
    pulse(irq_return_i);
    wait_for(lpm_ctrl_pkg::off_state, 1'b0);
  endtask

  task automatic t_backup();
    do_reset();
    bk_write(5'h1F, 8'hA5);
    enter(lpm_ctrl_pkg::rtc_only_state);
    chk(8'(core_supply_en_o), 8'h00);
    irq_io_i = 1'b1;
    tick(3);
    irq_io_i = 1'b0;
    chk(8'(mode_o), 8'h04);
    bk_read(5'h1F, 8'hA5);
    do_reset();
    bk_write(5'h00, 8'h3C);
    enter(lpm_ctrl_pkg::shutdown_state);
    chk(8'({core_supply_en_o, gpio_hold_o}), 8'h01);
    bk_read(5'h00, 8'h00);
  endtask

  initial
  begin
    {rst_n_i, mode_req_i, irq_any_i, irq_io_i, irq_rtc_i, irq_return_i, bk_we_i} = '0;
    {sub_main_clock_en_i, fll_en_i, dco_en_i, module_oscillator_clock_en_i, internal_reference_osc_en_i} = 5'h1F;
    {lf_periph_req_i, ext_clk_sel_i, mode_sel_i, bk_addr_i, bk_wdata_i} = '0;
    tick(2);
    rst_n_i = 1'b1;
    t_standby();
    t_off();
    t_backup();
    report_and_stop();
  end
endmodule
